/* hw/amp_gain_pkg.sv */
// Purpose: Constants for the input amplifier gain register bank
// Assumes: Byte-wide register port, 40 MHz core clock
// Notes: Offsets are byte addresses on the control port
package amp_gain_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_AMP2_CONTROL = 8'h25;
	localparam logic [7:0] OFS_AMP3_CONTROL = 8'h26;
	localparam logic [7:0] OFS_SLEW_CONTROL = 8'h27;
	localparam logic [7:0] OFS_BOOST_CONTROL = 8'h28;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_AMP_CONTROL = 8'h40;
	localparam logic [7:0] RST_SLEW_CONTROL = 8'h00;
	localparam logic [7:0] RST_BOOST_CONTROL = 8'h00;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_MIC_SELECT = 7;
	localparam int BIT_SILENCE = 6;
	localparam int GAIN_MSB = 5;
	localparam int SLEW_MSB = 5;
	localparam int SLEW_LSB = 4;
	localparam int BOOST_MSB = 3;
	localparam logic [5:0] GAIN_ZERO = 6'h00;
	// ----------------------------------------
	// Slew times in microseconds and cycle counts
	// ----------------------------------------
	localparam int CLK_MHZ = 40;
	localparam int SLEW_US_0 = 21500;
	localparam int SLEW_US_1 = 42500;
	localparam int SLEW_US_2 = 85000;
	localparam int SLEW_CYC_0 = SLEW_US_0 * CLK_MHZ;
	localparam int SLEW_CYC_1 = SLEW_US_1 * CLK_MHZ;
	localparam int SLEW_CYC_2 = SLEW_US_2 * CLK_MHZ;
	localparam logic [1:0] SLEW_CODE_1 = 2'h1;
	localparam logic [1:0] SLEW_CODE_2 = 2'h2;
endpackage

/* hw/amp_gain_slew.sv */
// Purpose: Ramps one amplifier's applied gain code toward its target
// Assumes: Step interval set by the caller, one step per interval
// Notes: Bypass jumps straight to the target
`timescale 1ns/10ps
module amp_gain_slew (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_in,
	// Control
	input wire logic [5:0] target_in,
	input wire logic bypass_in,
	input wire logic [31:0] step_cycles_in,
	// Result
	output logic [5:0] gain_out,
	output logic busy_out
);
	logic [31:0] tick;
	wire at_target = (gain_out == target_in);
	wire step_due = (tick >= step_cycles_in);
	wire [5:0] next_gain = (gain_out < target_in) ? gain_out + 6'h01 : gain_out - 6'h01;

	// Step the applied code one LSB per interval
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			gain_out <= 6'h00;
			tick <= 32'h0;
			busy_out <= 1'b0;
		end else if (bypass_in) begin
			gain_out <= target_in;
			tick <= 32'h0;
			busy_out <= 1'b0;
		end else if (at_target) begin
			tick <= 32'h0;
			busy_out <= 1'b0;
		end else if (step_due) begin
			gain_out <= next_gain;
			tick <= 32'h0;
			busy_out <= 1'b1;
		end else begin
			tick <= tick + 32'h1;
			busy_out <= 1'b1;
		end
	end
endmodule // amp_gain_slew

/* hw/input_amp_gain_regs.sv */
// Purpose: Control registers for input amplifiers 2 and 3 plus shared slew and boost
// Assumes: Byte-wide synchronous control port on the core clock
// Notes: Slew time sets the duration of a full-range gain change
//
// Behaviour
// - Control 2 bit 7 picks line input with amp off or mic input with amp on and slewing.
// - Control 2 bit 6 is a mute resetting to one, and while set the gain code is ignored.
// - Control 2 bits 5 to 0 are the gain code resetting to zero, minus 12 dB upward in steps.
// - Control 3 lives at 0x26 and resets to 0x40.
// - Control 3 bit 7 picks line input with amp off or mic input with amp on and slewing.
// - Control 3 bit 6 is a mute resetting to one that makes the gain code ignored.
// - Control 3 bits 5 to 0 use the same gain mapping as amplifier 2.
// - Slew control lives at 0x27, resets to zero, and bits 7 and 6 are reserved read/write.
// - Slew bits 3 to 0 disable slewing per amplifier, which then ignores the time field.
// - Boost lives at 0x28, resets to zero, with reserved upper four bits.
// - Boost bit n adds 10 dB to amplifier n's gain.
`timescale 1ns/10ps
module input_amp_gain_regs (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_in,
	// Control port
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_write_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	// Amplifier 2 analog controls
	output logic amp2_mic_select_out,
	output logic amp2_silence_out,
	output logic [5:0] amp2_gain_code_out,
	// Amplifier 3 analog controls
	output logic amp3_mic_select_out,
	output logic amp3_silence_out,
	output logic [5:0] amp3_gain_code_out,
	// Shared controls
	output logic [3:0] amp_ramp_off_out,
	output logic [3:0] amp_extra_gain_out,
	output logic [1:0] slew_time_out
);
	logic [7:0] input_amp2_control;
	logic [7:0] input_amp3_control;
	logic [7:0] amp_slew_control;
	logic [7:0] amp_boost_control;
	logic [7:0] next_rdata;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	wire wr_amp2 = reg_write_in && (reg_addr_in == amp_gain_pkg::OFS_AMP2_CONTROL);
	wire wr_amp3 = reg_write_in && (reg_addr_in == amp_gain_pkg::OFS_AMP3_CONTROL);
	wire wr_slew = reg_write_in && (reg_addr_in == amp_gain_pkg::OFS_SLEW_CONTROL);
	wire wr_boost = reg_write_in && (reg_addr_in == amp_gain_pkg::OFS_BOOST_CONTROL);

	// Readback mux; unmapped offsets read zero
	always_comb begin
		case (reg_addr_in)
			amp_gain_pkg::OFS_AMP2_CONTROL: next_rdata = input_amp2_control;
			amp_gain_pkg::OFS_AMP3_CONTROL: next_rdata = input_amp3_control;
			amp_gain_pkg::OFS_SLEW_CONTROL: next_rdata = amp_slew_control;
			amp_gain_pkg::OFS_BOOST_CONTROL: next_rdata = amp_boost_control;
			default: next_rdata = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	// Reserved bits are stored whole since they are read/write
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			input_amp2_control <= amp_gain_pkg::RST_AMP_CONTROL;
			input_amp3_control <= amp_gain_pkg::RST_AMP_CONTROL;
			amp_slew_control <= amp_gain_pkg::RST_SLEW_CONTROL;
			amp_boost_control <= amp_gain_pkg::RST_BOOST_CONTROL;
			reg_rdata_out <= 8'h00;
		end else begin
			if (wr_amp2) input_amp2_control <= reg_wdata_in;
			if (wr_amp3) input_amp3_control <= reg_wdata_in;
			if (wr_slew) amp_slew_control <= reg_wdata_in;
			if (wr_boost) amp_boost_control <= reg_wdata_in;
			reg_rdata_out <= next_rdata;
		end
	end

	// ----------------------------------------
	// Slew timing
	// ----------------------------------------
	// Reserved code 11 falls back to the shortest time
	wire [1:0] slew_code = amp_slew_control[amp_gain_pkg::SLEW_MSB:amp_gain_pkg::SLEW_LSB];
	wire [31:0] ramp_cycles = (slew_code == amp_gain_pkg::SLEW_CODE_2) ? amp_gain_pkg::SLEW_CYC_2 :
		(slew_code == amp_gain_pkg::SLEW_CODE_1) ? amp_gain_pkg::SLEW_CYC_1 :
		amp_gain_pkg::SLEW_CYC_0;
	// Full range is 63 steps, so each step gets one 63rd of the time
	wire [31:0] step_cycles = ramp_cycles / 32'd63;

	// Mute or line mode forces the target to zero gain code
	function automatic logic amp_live(input logic [7:0] control);
		return control[amp_gain_pkg::BIT_MIC_SELECT] && !control[amp_gain_pkg::BIT_SILENCE];
	endfunction
	wire amp2_active = amp_live(input_amp2_control);
	wire amp3_active = amp_live(input_amp3_control);
	wire [5:0] amp2_target = amp2_active ?
		input_amp2_control[amp_gain_pkg::GAIN_MSB:0] : amp_gain_pkg::GAIN_ZERO;
	wire [5:0] amp3_target = amp3_active ?
		input_amp3_control[amp_gain_pkg::GAIN_MSB:0] : amp_gain_pkg::GAIN_ZERO;
	wire [5:0] amp2_ramped;
	wire [5:0] amp3_ramped;

	// ----------------------------------------
	// Gain ramps
	// ----------------------------------------
	// Disabled slew bypasses the time field entirely
	amp_gain_slew u_amp2_slew (
		.sys_clk_in(sys_clk_in),
		.reset_in(reset_in),
		.target_in(amp2_target),
		.bypass_in(amp_slew_control[2]),
		.step_cycles_in(step_cycles),
		.gain_out(amp2_ramped),
		.busy_out()
	);
	amp_gain_slew u_amp3_slew (
		.sys_clk_in(sys_clk_in),
		.reset_in(reset_in),
		.target_in(amp3_target),
		.bypass_in(amp_slew_control[3]),
		.step_cycles_in(step_cycles),
		.gain_out(amp3_ramped),
		.busy_out()
	);

	// ----------------------------------------
	// Analog control outputs
	// ----------------------------------------
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			amp2_mic_select_out <= 1'b0;
			amp2_silence_out <= 1'b1;
			amp2_gain_code_out <= 6'h00;
			amp3_mic_select_out <= 1'b0;
			amp3_silence_out <= 1'b1;
			amp3_gain_code_out <= 6'h00;
			amp_ramp_off_out <= 4'h0;
			amp_extra_gain_out <= 4'h0;
			slew_time_out <= 2'h0;
		end else begin
			amp2_mic_select_out <= input_amp2_control[amp_gain_pkg::BIT_MIC_SELECT];
			amp2_silence_out <= input_amp2_control[amp_gain_pkg::BIT_SILENCE];
			amp2_gain_code_out <= amp2_ramped;
			amp3_mic_select_out <= input_amp3_control[amp_gain_pkg::BIT_MIC_SELECT];
			amp3_silence_out <= input_amp3_control[amp_gain_pkg::BIT_SILENCE];
			amp3_gain_code_out <= amp3_ramped;
			amp_ramp_off_out <= amp_slew_control[3:0];
			amp_extra_gain_out <= amp_boost_control[amp_gain_pkg::BOOST_MSB:0];
			slew_time_out <= (slew_code == 2'h3) ? 2'h0 : slew_code;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_mute_zero;
		@(posedge sys_clk_in) disable iff (reset_in)
		(input_amp2_control[6] && amp_slew_control[2]) |=> ##1 (amp2_gain_code_out == 6'h00);
	endproperty
	a_mute_zero: assert property (p_mute_zero) else $error("amp2 gain not zero while muted");
	property p_amp3_write;
		@(posedge sys_clk_in) disable iff (reset_in)
		wr_amp3 |=> (input_amp3_control == $past(reg_wdata_in));
	endproperty
	a_amp3_write: assert property (p_amp3_write) else $error("amp3 write lost");
	property p_boost_out;
		@(posedge sys_clk_in) disable iff (reset_in)
		wr_boost |=> ##1 (amp_extra_gain_out == $past(reg_wdata_in[3:0], 2));
	endproperty
	a_boost_out: assert property (p_boost_out) else $error("boost output wrong");
	property p_readback;
		@(posedge sys_clk_in) disable iff (reset_in)
		(reg_addr_in == amp_gain_pkg::OFS_SLEW_CONTROL) |=> (reg_rdata_out == $past(amp_slew_control));
	endproperty
	a_readback: assert property (p_readback) else $error("slew readback wrong");
	property p_bypass_gain;
		@(posedge sys_clk_in) disable iff (reset_in)
		(amp_slew_control[3] && amp3_active) ##1 (amp_slew_control[3] && $stable(amp3_target))
		|=> (amp3_gain_code_out == $past(amp3_target, 2));
	endproperty
	a_bypass_gain: assert property (p_bypass_gain) else $error("amp3 bypass gain wrong");
	property p_slew_reserved;
		@(posedge sys_clk_in) disable iff (reset_in)
		(slew_code == 2'h3) |=> (slew_time_out == 2'h0);
	endproperty
	a_slew_reserved: assert property (p_slew_reserved) else $error("reserved slew not mapped");
	property p_mic_out;
		@(posedge sys_clk_in) disable iff (reset_in)
		wr_amp2 |=> ##1 (amp2_mic_select_out == $past(reg_wdata_in[7], 2));
	endproperty
	a_mic_out: assert property (p_mic_out) else $error("amp2 mic select wrong");
	property p_amp3_mute;
		@(posedge sys_clk_in) disable iff (reset_in)
		wr_amp3 |=> ##1 (amp3_silence_out == $past(reg_wdata_in[6], 2));
	endproperty
	a_amp3_mute: assert property (p_amp3_mute) else $error("amp3 mute wrong");
	property p_line_zero;
		@(posedge sys_clk_in) disable iff (reset_in)
		(amp_slew_control[2] && !input_amp2_control[amp_gain_pkg::BIT_MIC_SELECT])
		|=> ##1 (amp2_gain_code_out == amp_gain_pkg::GAIN_ZERO);
	endproperty
	a_line_zero: assert property (p_line_zero) else $error("amp2 line gain wrong");
	// Amplifier 2 never moves more than one code per clock while slewing
	property p_ramp_step;
		@(posedge sys_clk_in) disable iff (reset_in)
		!amp_slew_control[2] |=> ((amp2_ramped == $past(amp2_ramped)) ||
			(amp2_ramped == $past(amp2_ramped) + 6'h01) ||
			(amp2_ramped == $past(amp2_ramped) - 6'h01));
	endproperty
	a_ramp_step: assert property (p_ramp_step) else $error("amp2 ramp jumped");
	property p_boost_store;
		@(posedge sys_clk_in) disable iff (reset_in)
		wr_boost |=> (amp_boost_control == $past(reg_wdata_in));
	endproperty
	a_boost_store: assert property (p_boost_store) else $error("boost write lost");
	property p_slew_store;
		@(posedge sys_clk_in) disable iff (reset_in)
		wr_slew |=> (amp_slew_control == $past(reg_wdata_in));
	endproperty
	a_slew_store: assert property (p_slew_store) else $error("slew write lost");
endmodule // input_amp_gain_regs

/* tb/input_amp_gain_regs_tb.sv */
// Purpose: Self-checking bench for the input amplifier gain register bank
// Assumes: Inputs driven on the falling edge, fixed random seed
// Notes: Slew bypass is used for gain checks since full ramps take ms
`timescale 1ns/10ps
module input_amp_gain_regs_tb;
	logic sys_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic reg_write_in = 1'b0;
	logic [7:0] reg_addr_in = 8'h00;
	logic [7:0] reg_wdata_in = 8'h00;
	logic [7:0] reg_rdata_out;
	logic amp2_mic_select_out, amp2_silence_out, amp3_mic_select_out, amp3_silence_out;
	logic [5:0] amp2_gain_code_out, amp3_gain_code_out;
	logic [3:0] amp_ramp_off_out, amp_extra_gain_out;
	logic [1:0] slew_time_out;
	int err_count = 0;
	int tests_run = 0;
	logic [7:0] shadow [4] = '{8'h40, 8'h40, 8'h00, 8'h00};
	logic [7:0] rv;
	// ----------------------------------------
	// Clock, design, helpers
	// ----------------------------------------
	always #12.5 sys_clk_in = ~sys_clk_in;
	input_amp_gain_regs u_input_amp_gain_regs (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
		.reg_addr_in(reg_addr_in), .reg_write_in(reg_write_in), .reg_wdata_in(reg_wdata_in),
		.reg_rdata_out(reg_rdata_out), .amp2_mic_select_out(amp2_mic_select_out),
		.amp2_silence_out(amp2_silence_out), .amp2_gain_code_out(amp2_gain_code_out),
		.amp3_mic_select_out(amp3_mic_select_out), .amp3_silence_out(amp3_silence_out),
		.amp3_gain_code_out(amp3_gain_code_out), .amp_ramp_off_out(amp_ramp_off_out),
		.amp_extra_gain_out(amp_extra_gain_out), .slew_time_out(slew_time_out));
	// Applied gain: only a live, unmuted mic path passes its code
	function automatic logic [7:0] exp_gain(input logic [7:0] c);
		return (c[7] && !c[6]) ? {2'h0, c[5:0]} : 8'h00;
	endfunction
	// Reserved code 11 falls back to the shortest time
	function automatic logic [7:0] exp_slew(input logic [7:0] s);
		return (s[5:4] == 2'h3) ? 8'h00 : {6'h0, s[5:4]};
	endfunction
	// One ramp step is the shortest slew time spread over 63 codes
	function automatic int exp_step();
		return amp_gain_pkg::SLEW_CYC_0 / 63;
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One-cycle write strobe, shadow kept only for mapped offsets
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk_in);
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_write_in = 1'b1;
		if (a >= amp_gain_pkg::OFS_AMP2_CONTROL && a <= amp_gain_pkg::OFS_BOOST_CONTROL)
			shadow[a - amp_gain_pkg::OFS_AMP2_CONTROL] = d;
		@(negedge sys_clk_in);
		reg_write_in = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk_in);
		reg_addr_in = a;
		@(negedge sys_clk_in);
		d = reg_rdata_out;
	endtask
	// Readback of all four registers plus every field output except the two gain codes
	task automatic check_all();
		@(negedge sys_clk_in);
		rd(amp_gain_pkg::OFS_AMP2_CONTROL, rv); check(rv, shadow[0]);
		rd(amp_gain_pkg::OFS_AMP3_CONTROL, rv); check(rv, shadow[1]);
		rd(amp_gain_pkg::OFS_SLEW_CONTROL, rv); check(rv, shadow[2]);
		rd(amp_gain_pkg::OFS_BOOST_CONTROL, rv); check(rv, shadow[3]);
		check({6'h0, amp2_mic_select_out, amp2_silence_out}, {6'h0, shadow[0][7:6]});
		check({6'h0, amp3_mic_select_out, amp3_silence_out}, {6'h0, shadow[1][7:6]});
		check({4'h0, amp_ramp_off_out}, {4'h0, shadow[2][3:0]});
		check({4'h0, amp_extra_gain_out}, {4'h0, shadow[3][3:0]});
		check({6'h0, slew_time_out}, exp_slew(shadow[2]));
	endtask
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Watchdog: one slew step plus register traffic stays well under 20000 cycles
	initial begin
		#(25 * 20000);
		err_count++;
		test_done();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [7:0] v;
		static logic [7:0] codes [5] = '{8'h00, 8'h01, 8'h10, 8'h3e, 8'h3f};
		static logic [7:0] modes [3] = '{8'h80, 8'hc0, 8'h00};
		void'($urandom(32'h25826175));
		repeat (5) @(negedge sys_clk_in);
		check({6'h0, amp2_silence_out, amp3_silence_out}, 8'h03);
		reset_in = 1'b0;
		check_all();
		check({2'h0, amp3_gain_code_out}, 8'h00);
		$display("test reset values done");
		// Random fills, reserved bits included, one idle cycle between writes
		for (int i = 0; i < 24; i++) begin
			v = 8'($urandom);
			wr(amp_gain_pkg::OFS_AMP2_CONTROL + 8'($urandom_range(0, 3)), v);
		end
		wr(amp_gain_pkg::OFS_SLEW_CONTROL, 8'hf5);
		check_all();
		for (int s = 0; s < 4; s++) begin
			wr(amp_gain_pkg::OFS_SLEW_CONTROL, 8'(s << 4) | 8'h0a);
			check_all();
		end
		$display("test random register traffic done");
		// Unmapped offsets: writes dropped, reads zero
		wr(8'h29, 8'hff);
		wr(8'h24, 8'hff);
		rd(8'h29, rv); check(rv, 8'h00);
		rd(8'h24, rv); check(rv, 8'h00);
		check_all();
		$display("test unmapped offsets done");
		// Gain code with slew bypassed on amps 2 and 3
		wr(amp_gain_pkg::OFS_SLEW_CONTROL, 8'h0c);
		for (int c = 0; c < 25; c++) begin
			v = (c < 15) ? (modes[c % 3] | codes[c / 3]) : 8'($urandom);
			wr(amp_gain_pkg::OFS_AMP2_CONTROL, v);
			wr(amp_gain_pkg::OFS_AMP3_CONTROL, v ^ 8'h3f);
			repeat (2) @(negedge sys_clk_in);
			check({2'h0, amp2_gain_code_out}, exp_gain(v));
			check({2'h0, amp3_gain_code_out}, exp_gain(v ^ 8'h3f));
		end
		$display("test gain codes done");
		// Slew enabled: a large step must not land at once
		wr(amp_gain_pkg::OFS_AMP2_CONTROL, 8'h00);
		repeat (2) @(negedge sys_clk_in);
		wr(amp_gain_pkg::OFS_SLEW_CONTROL, 8'h00);
		wr(amp_gain_pkg::OFS_AMP2_CONTROL, 8'hbf);
		repeat (4) @(negedge sys_clk_in);
		check({7'h0, amp2_gain_code_out === 6'h3f}, 8'h00);
		// First step lands one step interval after the write, not before
		repeat (exp_step() - 8) @(negedge sys_clk_in);
		check({2'h0, amp2_gain_code_out}, 8'h00);
		repeat (16) @(negedge sys_clk_in);
		check({2'h0, amp2_gain_code_out}, 8'h01);
		$display("test slew enabled done");
		test_done();
	end
endmodule // input_amp_gain_regs_tb
